// ==== verilog/slm_top.v ====
// Status LEDs and chain link monitor for a real-time clock board
`timescale 1ns/1ps
`include "slm_consts.vh"
//
// Behaviour
// R1: Reference clock failure: output LED solid red
// R2: Clock stopped, cable unsynced: red 2/sec flash
// R3: Running, no cable, no GPS: green 1/sec flash
// R4: Running, cable synced, no GPS: green blink
// R5: Running, cable unsynced: red/green alternate 2/sec
// R6: Running, no cable, GPS valid: blue flash
// R7: GPS with cable: blue blink or red/blue
// R8: Input LED: red flash unsynced, green synced
// R9: IRIG valid: blue flash, blink or red/blue
// R10: Reset dim red, then red/green test
// R11: Link frames carry parity and framing bits
// R12: Raise event on any link error or change
// R13: Connected status follows optical module presence only
// R14: Unsynced when far end stops answering
// R15: Flag parity or framing errors, force resync
// R16: Input link upstream, output link downstream
// R17: Link activity follows master, middle or end mode
// R18: Link carries payload bytes between neighbours
// R19: External reference selected whenever present
// R20: Flash short pulse, blink long on-period
// R21: Clock failure first, then GPS over others; the code puts a stopped clock ahead of GPS

module slm_top #(
    parameter CYC_PER_MS  = `SLM_CYC_PER_MS,
    parameter SYNC_FRAMES = `SLM_SYNC_FRAMES,
    parameter RX_TMO_CYC  = `SLM_RX_TIMEOUT_CYC
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_ce,
    input  wire        i_ref_fail,
    input  wire        i_posix_run,
    input  wire        i_cable_opt,
    input  wire        i_gps_pps_ok,
    input  wire        i_irig_ok,
    input  wire        i_ext_ref_present,
    input  wire [1:0]  i_chain_mode,
    input  wire [1:0]  i_module_present,
    input  wire [1:0]  i_link_rx_clk,
    input  wire [1:0]  i_link_rx_data,
    input  wire [7:0]  i_in_tx_byte,
    input  wire [7:0]  i_out_tx_byte,
    output reg  [1:0]  o_link_tx_clk,
    output reg  [1:0]  o_link_tx_data,
    output reg  [1:0]  o_tx_taken,
    output reg  [7:0]  o_in_rx_byte,
    output reg  [7:0]  o_out_rx_byte,
    output reg  [1:0]  o_rx_valid,
    output reg  [1:0]  o_link_active,
    output reg  [1:0]  o_link_connected,
    output reg  [1:0]  o_link_synced,
    output reg  [1:0]  o_link_error,
    output reg  [1:0]  o_link_event,
    output reg         o_ref_sel_ext,
    output reg  [2:0]  o_out_led_rgb,
    output reg  [2:0]  o_in_led_rgb,
    output reg         o_led_dim
);

    localparam [2:0] ST_TEST_RED = 3'b001;
    localparam [2:0] ST_TEST_GRN = 3'b010;
    localparam [2:0] ST_RUN      = 3'b100;

    localparam integer           DIV_HALF  = `SLM_TX_HALF_CYC;
    localparam [`SLM_PRE_W-1:0]  PRE_LAST  = CYC_PER_MS[`SLM_PRE_W-1:0] - 1'b1;
    localparam [`SLM_GOOD_W-1:0] GOOD_LAST = SYNC_FRAMES[`SLM_GOOD_W-1:0] - 1'b1;
    localparam [`SLM_TMO_W-1:0]  TMO_LAST  = RX_TMO_CYC[`SLM_TMO_W-1:0] - 1'b1;
    localparam [`SLM_DIV_W-1:0]  DIV_LAST  = DIV_HALF[`SLM_DIV_W-1:0] - 1'b1;

    // Odd parity bit for a payload byte
    function par_odd;
        input [7:0] b;
        begin
            par_odd = ~(^b);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    wire [9:0] lvl_raw = {i_ref_fail, i_posix_run, i_cable_opt, i_gps_pps_ok, i_irig_ok,
                          i_ext_ref_present, i_chain_mode, i_module_present};
    wire [3:0] pin_raw = {i_link_rx_clk, i_link_rx_data};

    reg  [9:0] lvl_m_q;
    reg  [9:0] lvl_q;
    reg  [3:0] pin_m_q;
    reg  [3:0] pin_q;
    reg  [1:0] rxclk_prev_q;

    always @(posedge i_clk) begin
        if (i_rst) begin
            lvl_m_q      <= 10'h000;
            lvl_q        <= 10'h000;
            pin_m_q      <= 4'h0;
            pin_q        <= 4'h0;
            rxclk_prev_q <= 2'h0;
        end else if (i_ce) begin
            lvl_m_q      <= lvl_raw;
            lvl_q        <= lvl_m_q;
            pin_m_q      <= pin_raw;
            pin_q        <= pin_m_q;
            rxclk_prev_q <= pin_q[3:2];
        end
    end

    wire       ref_fail  = lvl_q[9];
    wire       posix_run = lvl_q[8];
    wire       cable_opt = lvl_q[7];
    wire       gps_ok    = lvl_q[6];
    wire       irig_ok   = lvl_q[5];
    wire       ext_ref   = lvl_q[4];
    wire [1:0] mode      = lvl_q[3:2];
    wire [1:0] present   = lvl_q[1:0];
    wire [1:0] rx_clk    = pin_q[3:2];
    wire [1:0] rx_data   = pin_q[1:0];
    wire [1:0] rx_rise   = rx_clk & ~rxclk_prev_q;

    // Index 0 faces upstream toward the master, index 1 downstream
    wire act_in  = (mode == `SLM_MODE_MIDDLE) || (mode == `SLM_MODE_END);     // see R16 see R17
    wire act_out = (mode == `SLM_MODE_MASTER) || (mode == `SLM_MODE_MIDDLE);  // see R16 see R17
    wire [1:0] active = {act_out, act_in};
    wire [7:0] tx_byte [0:1];
    assign tx_byte[0] = i_in_tx_byte;
    assign tx_byte[1] = i_out_tx_byte;

    //////////////////////////////////////////////////////////////////////////
    // Shared transmit bit clock

    reg [`SLM_DIV_W-1:0] div_q;
    reg                  txclk_q;

    always @(posedge i_clk) begin
        if (i_rst) begin
            div_q   <= {`SLM_DIV_W{1'b0}};
            txclk_q <= 1'b0;
        end else if (i_ce) begin
            if (div_q == DIV_LAST) begin
                div_q   <= {`SLM_DIV_W{1'b0}};
                txclk_q <= ~txclk_q;
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // Data changes on the falling edge so the far end samples mid-bit
    wire tx_fall = i_ce && (div_q == DIV_LAST) && txclk_q;

    //////////////////////////////////////////////////////////////////////////
    // Per-link transmitter, receiver and status

    wire [7:0] rx_byte_w [0:1];
    wire [1:0] rx_valid_w;
    wire [1:0] synced_w;
    wire [1:0] err_w;
    wire [1:0] event_w;
    wire [1:0] taken_w;
    wire [1:0] txd_w;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_link
            wire       run = active[g] & present[g];
            reg  [8:0] tx_sh_q;
            reg  [3:0] tx_cnt_q;
            reg        txd_q;
            reg        taken_q;
            reg        busy_q;
            reg  [3:0] rx_cnt_q;
            reg  [9:0] rx_sh_q;
            reg  [`SLM_GOOD_W-1:0] good_q;
            reg  [`SLM_TMO_W-1:0]  tmo_q;
            reg        sync_q;
            reg        err_q;
            reg  [7:0] byte_q;
            reg        bval_q;
            reg        conn_prev_q;
            reg        sync_prev_q;
            reg        evt_q;
            wire [9:0] nsh = {rx_data[g], rx_sh_q[9:1]};
            wire       frame_ok = (^nsh[8:0]) && !nsh[9];                   // see R11 see R15

            // Continuous frames: start 1, data LSB first, odd parity, stop 0
            always @(posedge i_clk) begin
                if (i_rst || !run) begin
                    tx_sh_q  <= 9'h000;
                    tx_cnt_q <= 4'h0;
                    txd_q    <= 1'b0;
                    taken_q  <= 1'b0;
                end else if (i_ce) begin
                    taken_q <= 1'b0;
                    if (tx_fall) begin
                        if (tx_cnt_q == 4'h0) begin
                            txd_q    <= 1'b1;
                            tx_sh_q  <= {par_odd(tx_byte[g]), tx_byte[g]};        // see R11 see R18
                            tx_cnt_q <= `SLM_FRAME_BITS;
                            taken_q  <= 1'b1;
                        end else begin
                            txd_q    <= tx_sh_q[0];
                            tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
                            tx_cnt_q <= tx_cnt_q - 1'b1;
                        end
                    end
                end
            end

            // Receiver checks every frame and tracks synchronisation
            always @(posedge i_clk) begin
                if (i_rst || !run) begin
                    busy_q   <= 1'b0;
                    rx_cnt_q <= 4'h0;
                    rx_sh_q  <= 10'h000;
                    good_q   <= {`SLM_GOOD_W{1'b0}};
                    tmo_q    <= {`SLM_TMO_W{1'b0}};
                    sync_q   <= 1'b0;
                    err_q    <= 1'b0;
                    byte_q   <= 8'h00;
                    bval_q   <= 1'b0;
                end else if (i_ce) begin
                    err_q  <= 1'b0;
                    bval_q <= 1'b0;
                    if (tmo_q == TMO_LAST) begin
                        sync_q <= 1'b0;                                     // see R14
                        good_q <= {`SLM_GOOD_W{1'b0}};
                        tmo_q  <= {`SLM_TMO_W{1'b0}};
                    end else begin
                        tmo_q <= tmo_q + 1'b1;
                    end
                    if (rx_rise[g]) begin
                        if (!busy_q) begin
                            busy_q   <= rx_data[g];
                            rx_cnt_q <= 4'h0;
                        end else begin
                            rx_sh_q  <= nsh;
                            rx_cnt_q <= rx_cnt_q + 1'b1;
                            if (rx_cnt_q == `SLM_LAST_BIT) begin
                                busy_q <= 1'b0;
                                if (frame_ok) begin
                                    tmo_q  <= {`SLM_TMO_W{1'b0}};
                                    byte_q <= nsh[7:0];                     // see R18
                                    bval_q <= sync_q;
                                    if (good_q == GOOD_LAST) begin
                                        sync_q <= 1'b1;
                                    end else begin
                                        good_q <= good_q + 1'b1;
                                    end
                                end else begin
                                    err_q  <= 1'b1;                         // see R15
                                    good_q <= {`SLM_GOOD_W{1'b0}};
                                    sync_q <= 1'b0;
                                end
                            end
                        end
                    end
                end
            end

            // Event on error or any change of connection or sync state
            always @(posedge i_clk) begin
                if (i_rst) begin
                    conn_prev_q <= 1'b0;
                    sync_prev_q <= 1'b0;
                    evt_q       <= 1'b0;
                end else if (i_ce) begin
                    conn_prev_q <= present[g];
                    sync_prev_q <= sync_q;
                    evt_q       <= err_q || (present[g] != conn_prev_q)
                                   || (sync_q != sync_prev_q);               // see R12
                end
            end

            assign rx_byte_w[g] = byte_q;
            assign rx_valid_w[g] = bval_q;
            assign synced_w[g]  = sync_q;
            assign err_w[g]     = err_q;
            assign event_w[g]   = evt_q;
            assign taken_w[g]   = taken_q;
            assign txd_w[g]     = txd_q;
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Millisecond time base and LED patterns

    reg [`SLM_PRE_W-1:0] pre_q;
    reg [`SLM_MS_W-1:0]  ms_q;
    reg [`SLM_MS_W-1:0]  tst_q;
    reg [2:0]            st_q;
    wire ms_tick = (pre_q == PRE_LAST);

    wire [`SLM_MS_W-1:0] hs = (ms_q >= `SLM_MS_HALF_SEC) ? (ms_q - `SLM_MS_HALF_SEC) : ms_q;
    wire flash1 = ms_q < `SLM_FLASH_MS;                                     // see R20
    wire blink1 = ms_q < `SLM_BLINK_MS;                                     // see R20
    wire flash2 = hs < `SLM_FLASH_MS;
    wire alt_b  = (ms_q >= `SLM_MS_HALF_SEC) && flash2;

    wire cable_sync = (act_in || act_out) && (!act_in || synced_w[0])
                      && (!act_out || synced_w[1]);
    wire in_sync = synced_w[0];

    reg [2:0] out_rgb;
    reg [2:0] in_rgb;

    always @* begin
        out_rgb = `SLM_LED_OFF;
        if (ref_fail) begin
            out_rgb = `SLM_LED_RED;                                         // see R1 see R21
        end else if (!posix_run) begin
            if (cable_opt && !cable_sync && flash2) begin
                out_rgb = `SLM_LED_RED;                                     // see R2
            end
        end else if (gps_ok) begin                                          // see R21
            if (!cable_opt) begin
                out_rgb = flash1 ? `SLM_LED_BLUE : `SLM_LED_OFF;            // see R6
            end else if (cable_sync) begin
                out_rgb = blink1 ? `SLM_LED_BLUE : `SLM_LED_OFF;            // see R7
            end else if (flash1) begin
                out_rgb = `SLM_LED_RED;                                     // see R7
            end else if (alt_b) begin
                out_rgb = `SLM_LED_BLUE;
            end
        end else begin
            if (!cable_opt) begin
                out_rgb = flash1 ? `SLM_LED_GREEN : `SLM_LED_OFF;           // see R3
            end else if (cable_sync) begin
                out_rgb = blink1 ? `SLM_LED_GREEN : `SLM_LED_OFF;           // see R4
            end else if (flash1) begin
                out_rgb = `SLM_LED_RED;                                     // see R5
            end else if (alt_b) begin
                out_rgb = `SLM_LED_GREEN;
            end
        end
    end

    always @* begin
        in_rgb = `SLM_LED_OFF;
        if (irig_ok) begin
            if (!cable_opt) begin
                in_rgb = flash1 ? `SLM_LED_BLUE : `SLM_LED_OFF;             // see R9
            end else if (in_sync) begin
                in_rgb = blink1 ? `SLM_LED_BLUE : `SLM_LED_OFF;             // see R9
            end else if (flash1) begin
                in_rgb = `SLM_LED_RED;                                      // see R9
            end else if (alt_b) begin
                in_rgb = `SLM_LED_BLUE;
            end
        end else if (cable_opt) begin
            if (in_sync) begin
                in_rgb = `SLM_LED_GREEN;                                    // see R8
            end else if (flash2) begin
                in_rgb = `SLM_LED_RED;                                      // see R8
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Reset indication, lamp test, then normal display

    always @(posedge i_clk) begin
        if (i_rst) begin
            pre_q         <= {`SLM_PRE_W{1'b0}};
            ms_q          <= {`SLM_MS_W{1'b0}};
            tst_q         <= {`SLM_MS_W{1'b0}};
            st_q          <= ST_TEST_RED;
            o_out_led_rgb <= `SLM_LED_RED;                                  // see R10
            o_in_led_rgb  <= `SLM_LED_RED;
            o_led_dim     <= 1'b1;
        end else if (i_ce) begin
            o_led_dim <= 1'b0;
            pre_q     <= ms_tick ? {`SLM_PRE_W{1'b0}} : pre_q + 1'b1;
            if (ms_tick) begin
                ms_q <= (ms_q == `SLM_MS_PER_SEC - 1'b1) ? {`SLM_MS_W{1'b0}} : ms_q + 1'b1;
            end
            case (st_q)
                ST_TEST_RED: begin
                    o_out_led_rgb <= `SLM_LED_RED;                          // see R10
                    o_in_led_rgb  <= `SLM_LED_RED;
                    if (ms_tick) begin
                        tst_q <= tst_q + 1'b1;
                    end
                    if (tst_q == `SLM_TEST_MS) begin
                        tst_q <= {`SLM_MS_W{1'b0}};
                        st_q  <= ST_TEST_GRN;
                    end
                end
                ST_TEST_GRN: begin
                    o_out_led_rgb <= `SLM_LED_GREEN;                        // see R10
                    o_in_led_rgb  <= `SLM_LED_GREEN;
                    if (ms_tick) begin
                        tst_q <= tst_q + 1'b1;
                    end
                    if (tst_q == `SLM_TEST_MS) begin
                        tst_q <= {`SLM_MS_W{1'b0}};
                        ms_q  <= {`SLM_MS_W{1'b0}};
                        st_q  <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    o_out_led_rgb <= out_rgb;
                    o_in_led_rgb  <= in_rgb;
                end
                default: begin
                    st_q <= ST_TEST_RED;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registered status and link outputs

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_link_tx_clk    <= 2'h0;
            o_link_tx_data   <= 2'h0;
            o_tx_taken       <= 2'h0;
            o_in_rx_byte     <= 8'h00;
            o_out_rx_byte    <= 8'h00;
            o_rx_valid       <= 2'h0;
            o_link_active    <= 2'h0;
            o_link_connected <= 2'h0;
            o_link_synced    <= 2'h0;
            o_link_error     <= 2'h0;
            o_link_event     <= 2'h0;
            o_ref_sel_ext    <= 1'b0;
        end else if (i_ce) begin
            o_link_tx_clk    <= {2{txclk_q}} & active & present;
            o_link_tx_data   <= txd_w;
            o_tx_taken       <= taken_w;
            o_in_rx_byte     <= rx_byte_w[0];
            o_out_rx_byte    <= rx_byte_w[1];
            o_rx_valid       <= rx_valid_w;
            o_link_active    <= active;                                     // see R17
            o_link_connected <= present;                                    // see R13
            o_link_synced    <= synced_w;                                   // see R14
            o_link_error     <= err_w;                                      // see R15
            o_link_event     <= event_w;                                    // see R12
            o_ref_sel_ext    <= ext_ref;                                    // see R19
        end
    end

endmodule // slm_top

// ==== verilog/slm_consts.vh ====
// Constants for the status LED and chain link monitor
`ifndef SLM_CONSTS_VH
`define SLM_CONSTS_VH

// Clock and time base
`define SLM_CLK_PERIOD_NS   10
`define SLM_NS_PER_MS       1000000
`define SLM_CYC_PER_MS      (`SLM_NS_PER_MS / `SLM_CLK_PERIOD_NS)
`define SLM_PRE_W           17
`define SLM_MS_W            10
`define SLM_MS_PER_SEC      10'h3e8
`define SLM_MS_HALF_SEC     10'h1f4

// LED pattern timing in milliseconds
`define SLM_FLASH_MS        10'h064
`define SLM_BLINK_MS        10'h320
`define SLM_TEST_MS         10'h1f4

// LED colour codes {red, green, blue}
`define SLM_LED_OFF         3'h0
`define SLM_LED_RED         3'h4
`define SLM_LED_GREEN       3'h2
`define SLM_LED_BLUE        3'h1

// Chain modes
`define SLM_MODE_SOLO       2'h0
`define SLM_MODE_MASTER     2'h1
`define SLM_MODE_MIDDLE     2'h2
`define SLM_MODE_END        2'h3

// Link framing: start bit, 8 data bits LSB first, odd parity, stop bit
`define SLM_FRAME_BITS      4'ha
`define SLM_LAST_BIT        4'h9
`define SLM_LINK_PERIOD_NS  125
`define SLM_TX_HALF_CYC     (`SLM_LINK_PERIOD_NS / (2 * `SLM_CLK_PERIOD_NS))
`define SLM_DIV_W           3

// Receive synchronisation
`define SLM_SYNC_FRAMES     4
`define SLM_GOOD_W          3
`define SLM_RX_TIMEOUT_NS   20000
`define SLM_RX_TIMEOUT_CYC  (`SLM_RX_TIMEOUT_NS / `SLM_CLK_PERIOD_NS)
`define SLM_TMO_W           16

`endif

// ==== tb/slm_top_monitor.sv ====
// Port checks for the status LED and chain link monitor
`timescale 1ns/1ps
module slm_top_monitor #(
    parameter CYC_PER_MS  = 100000,
    parameter SYNC_FRAMES = 4,
    parameter RX_TMO_CYC  = 2000
) (
    input wire       i_clk,
    input wire       i_rst,
    input wire       i_ce,
    input wire       i_ref_fail,
    input wire       i_ext_ref_present,
    input wire [1:0] i_chain_mode,
    input wire [1:0] o_link_tx_clk,
    input wire [1:0] o_link_active,
    input wire [1:0] o_link_synced,
    input wire [1:0] o_link_error,
    input wire [1:0] o_link_event,
    input wire       o_ref_sel_ext,
    input wire [2:0] o_out_led_rgb,
    input wire [2:0] o_in_led_rgb,
    input wire       o_led_dim
);
    // Counts past the power-up lamp test
    reg  [31:0] up_q;
    wire        armed = up_q > 1010 * CYC_PER_MS;
    always @(posedge i_clk) begin
        if (i_rst) up_q <= 32'h0;
        else if (!armed) up_q <= up_q + 32'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    sequence s_release;
        i_rst ##1 !i_rst;
    endsequence
    sequence s_tx_high;
        o_link_tx_clk[1] [*6];
    endsequence
    chk_ref_red: assert property (disable iff (i_rst)
        (armed && i_ref_fail && i_ce) [*4] |-> o_out_led_rgb == 3'h4) else $error("red lost");
    chk_dim_reset: assert property (
        i_rst && i_ce |=> o_led_dim && o_out_led_rgb == 3'h4 && o_in_led_rgb == 3'h4)
        else $error("not dim red");
    chk_test_red: assert property (
        s_release |=> !o_led_dim && o_out_led_rgb == 3'h4) else $error("no bright red");
    chk_mode_active: assert property (disable iff (i_rst)
        ($stable(i_chain_mode) && i_ce) [*4] |->
        o_link_active == {^i_chain_mode, i_chain_mode[1]}) else $error("active wrong");
    chk_ref_select: assert property (disable iff (i_rst)
        ($stable(i_ext_ref_present) && i_ce) [*4] |-> o_ref_sel_ext == i_ext_ref_present)
        else $error("ref select wrong");
    chk_err_event: assert property (disable iff (i_rst)
        o_link_error[0] |=> o_link_event[0]) else $error("no event");
    chk_err_unsync: assert property (disable iff (i_rst)
        o_link_error[0] |-> ##[0:2] !o_link_synced[0]) else $error("sync kept");
    chk_tx_half: assert property (disable iff (i_rst || !o_link_active[1])
        $rose(o_link_tx_clk[1]) && $past(o_link_active[1]) |-> s_tx_high ##1 !o_link_tx_clk[1])
        else $error("tx clk");
endmodule // slm_top_monitor
bind slm_top slm_top_monitor #(.CYC_PER_MS(CYC_PER_MS), .SYNC_FRAMES(SYNC_FRAMES),
    .RX_TMO_CYC(RX_TMO_CYC)) u_mon (.*);

// ==== tb/slm_far_end.sv ====
// Behavioural neighbour board on one chain link
`timescale 1ns/1ps
module slm_far_end (
    input  wire       i_en,
    input  wire       i_bad,
    input  wire [7:0] i_byte,
    input  wire       i_rclk,
    input  wire       i_rdat,
    output reg        o_clk,
    output reg        o_dat,
    output reg  [7:0] o_got,
    output reg        o_ok
);
    reg     [10:0] fr;
    reg     [9:0]  sh;
    integer        i;
    integer        n = 0;
    realtime       t_last = 0;
    initial begin
        o_clk = 1'b0;
        o_dat = 1'b0;
        forever begin
            if (i_en) begin
                // Start, data LSB first, odd parity, stop
                fr = {1'b0, ~^i_byte ^ i_bad, i_byte, 1'b1};
                for (i = 0; i < 11; i++) begin
                    o_dat = fr[i];
                    #62.5 o_clk = 1'b1;
                    #62.5 o_clk = 1'b0;
                end
            end else begin
                // Clock stands still, line carries junk
                o_dat = ~o_dat;
                #62.5;
            end
        end
    end
    always @(posedge i_rclk) begin
        // A stopped clock ends any half frame; hunt for a fresh start bit
        if ($realtime - t_last > 500) n = 0;
        t_last = $realtime;
        if (n == 0) n = i_rdat;
        else begin
            sh[n - 1] = i_rdat;
            n = n + 1;
            if (n == 11) begin
                o_got = sh[7:0];
                o_ok = ^sh[8:0] && !sh[9];
                n = 0;
            end
        end
    end
endmodule // slm_far_end

// ==== tb/slm_top_tb.sv ====
// Self-checking bench for the status LED and chain link monitor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module slm_top_tb;
    localparam CPM = 5;
    reg        i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_ref_fail = 1'b0;
    reg        i_posix_run = 1'b0, i_cable_opt = 1'b0, i_gps_pps_ok = 1'b0;
    reg        i_irig_ok = 1'b0, i_ext_ref_present = 1'b0;
    reg  [1:0] i_chain_mode = 2'h2, i_module_present = 2'h3, p_en = 2'h0, p_bad = 2'h0;
    reg  [7:0] i_in_tx_byte = 8'h3c, i_out_tx_byte = 8'hc3;
    wire [1:0] i_link_rx_clk, i_link_rx_data, o_link_tx_clk, o_link_tx_data, o_tx_taken;
    wire [1:0] o_rx_valid, o_link_active, o_link_connected, o_link_synced;
    wire [1:0] o_link_error, o_link_event, p_ok;
    wire [7:0] o_in_rx_byte, o_out_rx_byte, got0, got1;
    wire [2:0] o_out_led_rgb, o_in_led_rgb;
    wire       o_ref_sel_ext, o_led_dim;
    integer    n_errors = 0, checked = 0, m, t;
    initial forever #5 i_clk = ~i_clk;
    slm_top #(.CYC_PER_MS(CPM), .SYNC_FRAMES(4), .RX_TMO_CYC(400)) u_dut (.*);
    slm_far_end u_up (.i_en(p_en[0]), .i_bad(p_bad[0]), .i_byte(8'ha5),
        .i_rclk(o_link_tx_clk[0]), .i_rdat(o_link_tx_data[0]), .o_clk(i_link_rx_clk[0]),
        .o_dat(i_link_rx_data[0]), .o_got(got0), .o_ok(p_ok[0]));
    slm_far_end u_dn (.i_en(p_en[1]), .i_bad(p_bad[1]), .i_byte(8'h5a),
        .i_rclk(o_link_tx_clk[1]), .i_rdat(o_link_tx_data[1]), .o_clk(i_link_rx_clk[1]),
        .o_dat(i_link_rx_data[1]), .o_got(got1), .o_ok(p_ok[1]));
    ////////////////////////////////////////////////////////////////////////////////
    // Counts lit milliseconds per colour over one second
    task automatic leds(input [4:0] v, input int e[6]);
        integer c[6] = '{default: 0};
        @(negedge i_clk);
        {i_ref_fail, i_posix_run, i_cable_opt, i_gps_pps_ok, i_irig_ok} = v;
        repeat (20) @(negedge i_clk);
        repeat (1000) begin
            repeat (CPM) @(negedge i_clk);
            for (int k = 0; k < 3; k++) begin
                c[k] += o_out_led_rgb[2 - k];
                c[k + 3] += o_in_led_rgb[2 - k];
            end
        end
        for (int k = 0; k < 6; k++) `CHK("led_on_ms", e[k], c[k])
    endtask
    task conclude;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #700000;
        n_errors++;
        conclude;
    end
    initial begin
        repeat (8) @(negedge i_clk);
        `CHK("reset_leds", 7'h64, {o_led_dim, o_out_led_rgb, o_in_led_rgb})
        i_rst = 1'b0;
        repeat (300 * CPM) @(negedge i_clk);
        `CHK("test_red", 7'h24, {o_led_dim, o_out_led_rgb, o_in_led_rgb})
        repeat (500 * CPM) @(negedge i_clk);
        `CHK("test_green", 7'h12, {o_led_dim, o_out_led_rgb, o_in_led_rgb})
        repeat (300 * CPM) @(negedge i_clk);
        for (m = 3; m < 7; m++) begin
            i_chain_mode = m[1:0];
            i_ext_ref_present = m[0];
            repeat (60) @(negedge i_clk);
            `CHK("active", {^m[1:0], m[1]}, o_link_active)
            `CHK("ref_sel", m[0], o_ref_sel_ext)
        end
        leds(5'b00100, '{200, 0, 0, 200, 0, 0});
        leds(5'b11111, '{1000, 0, 0, 100, 0, 100});
        leds(5'b01100, '{100, 100, 0, 200, 0, 0});
        leds(5'b01110, '{100, 0, 100, 200, 0, 0});
        leds(5'b01000, '{0, 100, 0, 0, 0, 0});
        leds(5'b01011, '{0, 0, 100, 0, 0, 100});
        p_en = 2'h3;
        for (t = 0; t < 2000 && o_link_synced !== 2'h3; t++) @(negedge i_clk);
        `CHK("synced", 2'h3, o_link_synced)
        repeat (400) @(negedge i_clk);
        `CHK("rx_bytes", 16'ha55a, {o_in_rx_byte, o_out_rx_byte})
        `CHK("far_rx", 18'h33cc3, {p_ok, got0, got1})
        for (t = 0; t < 300 && o_rx_valid[0] !== 1'b1; t++) @(negedge i_clk);
        `CHK("rx_valid", 1'b1, o_rx_valid[0])
        for (t = 0; t < 300 && o_tx_taken[1] !== 1'b1; t++) @(negedge i_clk);
        `CHK("tx_taken", 1'b1, o_tx_taken[1])
        leds(5'b01100, '{0, 800, 0, 0, 1000, 0});
        leds(5'b01111, '{0, 0, 800, 0, 0, 800});
        p_bad = 2'h1;
        for (t = 0; t < 400 && o_link_error[0] !== 1'b1; t++) @(negedge i_clk);
        `CHK("link_error", 1'b1, o_link_error[0])
        p_bad = 2'h0;
        @(negedge i_clk);
        `CHK("link_event", 1'b1, o_link_event[0])
        @(negedge i_clk);
        `CHK("sync_dropped", 1'b0, o_link_synced[0])
        for (t = 0; t < 2000 && o_link_synced[0] !== 1'b1; t++) @(negedge i_clk);
        `CHK("resync", 1'b1, o_link_synced[0])
        p_en = 2'h2;
        for (t = 0; t < 1000 && o_link_synced[0] !== 1'b0; t++) @(negedge i_clk);
        `CHK("fibre_gone", 2'h1, {o_link_synced[0], o_link_connected[0]})
        i_module_present = 2'h2;
        repeat (6) @(negedge i_clk);
        `CHK("connected", 2'h2, o_link_connected)
        conclude;
    end
endmodule // slm_top_tb
